// *** rtl/onchip_memory_decode.sv ***
/*
 * On-chip RAM and ROM decoder with the system control register.
 * Holds the RAM array itself; the ROM array and the external bus sit
 * outside and answer combinationally within the request cycle.
 * Assumes the mode pins are asynchronous and stable around reset release.
 */
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
module onchip_memory_decode
    import onchip_memory_decode_pkg::*;
#(
    parameter int RAM_BYTES = RAM_BYTES_DEFAULT,
    parameter int ROM_KBYTES = ROM_KBYTES_DEFAULT
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic mode_select_hi,
    input wire logic mode_select_lo,
    input wire cpu_request_s cpu_req,
    output logic [15:0] cpu_rdata,
    output logic cpu_done,
    output logic cpu_halt,
    output logic rom_select,
    input wire logic [15:0] rom_rdata,
    output logic ext_select,
    output logic ext_read,
    output logic ext_write,
    input wire logic [15:0] ext_rdata,
    output mode_e operating_mode,
    output system_control_s system_control
);

    // Word count of the RAM and the first address of its window.
    localparam int RAM_WORDS = RAM_BYTES / 2;
    localparam int RAM_INDEX_BITS = $clog2(RAM_WORDS);
    localparam logic [16:0] RAM_BASE_WIDE = 17'(32'(RAM_END_ADDR) + 1 - RAM_BYTES);
    localparam logic [15:0] RAM_BASE_ADDR = RAM_BASE_WIDE[15:0]; // R2
    // One past the last ROM byte; 17 bits so 64 KB would still fit.
    localparam logic [16:0] ROM_LIMIT = 17'(32'(ROM_BASE_ADDR) + ROM_KBYTES * 1024); // R11

    // Every flip-flop of the block except the RAM array.
    typedef struct packed {
        logic hi_meta;
        logic hi_sync;
        logic lo_meta;
        logic lo_sync;
        mode_e mode;
        system_control_s ctrl;
        logic [15:0] rdata;
        logic done;
    } state_s;

    state_s state;
    state_s next_state;

    // The RAM is kept apart from the state struct; it is too big for one.
    logic [15:0] ram [RAM_WORDS];

    // Decode terms of the current request.
    logic halted;
    logic expanded;
    logic request;
    logic reg_hit;
    logic ram_window;
    logic rom_window;
    logic ram_internal;
    logic ram_inert;
    logic external;
    logic [RAM_INDEX_BITS-1:0] ram_index;
    logic [15:0] ram_word;
    logic [1:0] ram_lane_write;

    // True when the address falls in the RAM window.
    function automatic logic in_ram_window(input logic [15:0] addr);
        in_ram_window = (addr >= RAM_BASE_ADDR) && (addr <= RAM_END_ADDR); // R2
    endfunction : in_ram_window

    // True when the address falls inside the fitted ROM.
    function automatic logic in_rom_window(input logic [15:0] addr);
        in_rom_window = (addr >= ROM_BASE_ADDR) && ({1'b0, addr} < ROM_LIMIT); // R15 R11
    endfunction : in_rom_window

    // Maps the mode pins to a mode: 00 program, 01, 10, 11.
    function automatic mode_e pins_to_mode(input logic hi, input logic lo);
        case ({hi, lo})
            2'b01: pins_to_mode = MODE_EXPANDED_ROMLESS; // R13
            2'b10: pins_to_mode = MODE_EXPANDED; // R13
            2'b11: pins_to_mode = MODE_SINGLE_CHIP; // R13
            default: pins_to_mode = MODE_PROGRAM;
        endcase
    endfunction : pins_to_mode

    // Picks the answer for the access size; bytes land in the low lane.
    // The even address of a word is its upper byte.
    function automatic logic [15:0] fit_size(input logic [15:0] word_data,
                                             input logic word, input logic odd);
        if (word) begin
            fit_size = word_data;
        end else if (odd) begin
            fit_size = {8'h00, word_data[7:0]};
        end else begin
            fit_size = {8'h00, word_data[15:8]};
        end
    endfunction : fit_size

    // Packs the control register for a read; fixed bits read as one.
    function automatic logic [7:0] ctrl_to_byte(input system_control_s c);
        ctrl_to_byte = {c.standby_select, c.settle_select, 1'b1,
                        c.nmi_edge_select, 1'b1, c.onchip_ram_enable}; // R9
    endfunction : ctrl_to_byte

    // Unpacks a written byte; the fixed bits are simply dropped.
    function automatic system_control_s byte_to_ctrl(input logic [7:0] b);
        byte_to_ctrl.standby_select = b[CTRL_STANDBY_BIT];
        byte_to_ctrl.settle_select = b[CTRL_SETTLE_LSB +: 3];
        byte_to_ctrl.nmi_edge_select = b[CTRL_NMI_EDGE_BIT];
        byte_to_ctrl.onchip_ram_enable = b[CTRL_RAM_ENABLE_BIT];
    endfunction : byte_to_ctrl

    // Address decode, purely combinational so routing is known at once.
    always_comb begin
        halted = (state.mode == MODE_PROGRAM); // R14
        expanded = (state.mode == MODE_EXPANDED_ROMLESS) || (state.mode == MODE_EXPANDED);
        request = cpu_req.read || cpu_req.write;
        // A word at FFC4 or a byte at FFC4 reaches the control register.
        reg_hit = ({cpu_req.addr[15:1], 1'b0} == SYSTEM_CONTROL_ADDR)
                  && (cpu_req.word || !cpu_req.addr[0]); // R3
        ram_window = in_ram_window(cpu_req.addr); // R16
        // Mode 1 has no ROM, so its ROM range is left to the outside.
        rom_window = in_rom_window(cpu_req.addr)
                     && (state.mode != MODE_EXPANDED_ROMLESS); // R13 R16
        ram_internal = ram_window && state.ctrl.onchip_ram_enable && !halted; // R6
        ram_inert = ram_window && !state.ctrl.onchip_ram_enable
                    && (state.mode == MODE_SINGLE_CHIP); // R7 R8
        // Only the expanded modes own an external bus.
        external = expanded && !reg_hit && !rom_window && !ram_internal; // R6
    end

    // RAM word index and byte lanes of a write.
    always_comb begin
        ram_index = RAM_INDEX_BITS'((cpu_req.addr - RAM_BASE_ADDR) >> 1);
        ram_word = ram[ram_index];
        ram_lane_write = 2'b00;
        // A write to a disabled single-chip RAM falls through untouched.
        if (ram_internal && cpu_req.write) begin // R7
            if (cpu_req.word) begin
                ram_lane_write = 2'b11; // R1
            end else if (cpu_req.addr[0]) begin
                ram_lane_write = 2'b01; // R1
            end else begin
                ram_lane_write = 2'b10; // R1
            end
        end
    end

    // Outward strobes follow the request in the same cycle.
    always_comb begin
        cpu_halt = halted; // R14
        rom_select = rom_window && cpu_req.read && !halted; // R10
        ext_select = external && request; // R6
        ext_read = external && cpu_req.read; // R6
        ext_write = external && cpu_req.write; // R6
    end

    // Next-state logic: synchroniser, mode capture, register, answer.
    always_comb begin
        next_state = state;
        // The pins pass two flops before any decode looks at them.
        next_state.hi_meta = mode_select_hi;
        next_state.hi_sync = state.hi_meta;
        next_state.lo_meta = mode_select_lo;
        next_state.lo_sync = state.lo_meta;
        next_state.done = 1'b0;
        next_state.rdata = state.rdata;
        if (!resetn) begin
            // The mode tracks the pins until the last reset edge, then freezes.
            next_state.mode = pins_to_mode(state.hi_sync, state.lo_sync); // R12
            next_state.ctrl = byte_to_ctrl(SYSTEM_CONTROL_RESET); // R4 R9
            next_state.rdata = 16'h0000;
        end else if (!halted && request) begin
            // Every accepted access completes in its second state.
            next_state.done = 1'b1; // R1 R10
            if (reg_hit && cpu_req.write) begin
                // Only software writes and reset touch the enable; standby never does.
                next_state.ctrl = byte_to_ctrl(cpu_req.word ? cpu_req.wdata[15:8]
                                                            : cpu_req.wdata[7:0]); // R3 R5 R9
            end
            if (cpu_req.read) begin
                if (reg_hit) begin
                    next_state.rdata = fit_size({ctrl_to_byte(state.ctrl), 8'h00},
                                                cpu_req.word, cpu_req.addr[0]); // R9
                end else if (ram_internal) begin
                    next_state.rdata = fit_size(ram_word, cpu_req.word, cpu_req.addr[0]); // R1
                end else if (rom_window) begin
                    next_state.rdata = fit_size(rom_rdata, cpu_req.word, cpu_req.addr[0]); // R10
                end else if (external) begin
                    next_state.rdata = fit_size(ext_rdata, cpu_req.word, cpu_req.addr[0]);
                end else if (!cpu_req.word) begin
                    // Inert RAM bytes and unmapped single-chip bytes read high in the low lane.
                    next_state.rdata = {8'h00, INERT_READ_BYTE}; // R8
                end else begin
                    // Inert RAM words and unmapped single-chip words read all high.
                    next_state.rdata = INERT_READ_WORD; // R8
                end
            end
        end
    end

    // The one register stage of the block.
    always_ff @(posedge clock) begin
        state <= next_state;
    end

    // RAM write port; each byte lane is written on its own.
    always_ff @(posedge clock) begin
        if (ram_lane_write[1]) begin
            // A byte write at an even address carries its byte in the low data lane.
            ram[ram_index][15:8] <= cpu_req.word ? cpu_req.wdata[15:8]
                                                 : cpu_req.wdata[7:0]; // R1
        end
        if (ram_lane_write[0]) begin
            ram[ram_index][7:0] <= cpu_req.wdata[7:0]; // R1
        end
    end

    // Registered answers and state views.
    always_comb begin
        cpu_rdata = state.rdata;
        cpu_done = state.done;
        operating_mode = state.mode;
        system_control = state.ctrl;
    end

endmodule : onchip_memory_decode

// *** rtl/onchip_memory_decode_pkg.sv ***
/*
 * Constants, types and the memory map for the on-chip memory decoder.
 * Assumes one 125 MHz clock and a CPU that issues one strobe at a time.
 */
// Notes on behaviour
// R1: RAM gives 16-bit byte/word access, two states.
// R2: RAM window ends FF7F, base set by size.
// R3: Control bit 0 at FFC4 enables RAM.
// R4: Reset sets the RAM enable bit.
// R5: Standby leaves the RAM enable bit alone.
// R6: Expanded modes: disabled RAM window goes external.
// R7: Single-chip, RAM disabled: writes do nothing.
// R8: Single-chip, RAM disabled: reads return FF.
// R9: Control resets to 0B; bits 3,1 fixed.
// R10: ROM gives 16-bit reads in two states.
// R11: ROM decode covers exactly the fitted size.
// R12: Mode pins captured as reset releases.
// R13: 01 ROM off; 10, 11 ROM on.
// R14: Programming mode halts all CPU access.
// R15: ROM starts at address 0000.
// R16: Window hits decoded combinationally from address.
package onchip_memory_decode_pkg;

    // Clock rate and the access length in states.
    localparam int CLOCK_MHZ = 125;
    localparam int ACCESS_STATES = 2;

    // Address map.
    localparam logic [15:0] SYSTEM_CONTROL_ADDR = 16'hFFC4;
    localparam logic [15:0] RAM_END_ADDR = 16'hFF7F;
    localparam logic [15:0] ROM_BASE_ADDR = 16'h0000;

    // Default memory sizes of the largest variant.
    localparam int RAM_BYTES_DEFAULT = 2048;
    localparam int ROM_KBYTES_DEFAULT = 60;

    // Control register reset value and its bit positions.
    localparam logic [7:0] SYSTEM_CONTROL_RESET = 8'h0B;
    localparam int CTRL_RAM_ENABLE_BIT = 0;
    localparam int CTRL_FIXED_LO_BIT = 1;
    localparam int CTRL_NMI_EDGE_BIT = 2;
    localparam int CTRL_FIXED_HI_BIT = 3;
    localparam int CTRL_SETTLE_LSB = 4;
    localparam int CTRL_STANDBY_BIT = 7;

    // Value returned by a read of an inert location.
    localparam logic [15:0] INERT_READ_WORD = 16'hFFFF;
    localparam logic [7:0] INERT_READ_BYTE = 8'hFF;

    // Operating modes, decoded from the two mode pins.
    typedef enum logic [1:0] {
        MODE_PROGRAM,
        MODE_EXPANDED_ROMLESS,
        MODE_EXPANDED,
        MODE_SINGLE_CHIP
    } mode_e;

    // Software view of the system control register.
    typedef struct packed {
        logic standby_select;
        logic [2:0] settle_select;
        logic nmi_edge_select;
        logic onchip_ram_enable;
    } system_control_s;

    // One CPU request as seen in its first state.
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic word;
        logic write;
        logic read;
    } cpu_request_s;

endpackage : onchip_memory_decode_pkg

// *** tb/onchip_memory_decode_monitor.sv ***
/* Port checker for the memory decoder.
   Assumes it is bound onto the decoder with the same sizes. */
`timescale 1ns/10ps
module onchip_memory_decode_monitor
    import onchip_memory_decode_pkg::*;
#(
    parameter int RAM_BYTES = RAM_BYTES_DEFAULT,
    parameter int ROM_KBYTES = ROM_KBYTES_DEFAULT
) (
    input wire logic clock,
    input wire logic resetn,
    input wire cpu_request_s cpu_req,
    input wire logic [15:0] cpu_rdata,
    input wire logic cpu_done,
    input wire logic cpu_halt,
    input wire logic rom_select,
    input wire logic ext_select,
    input wire logic ext_write,
    input wire mode_e operating_mode,
    input wire system_control_s system_control
);
    // Request, window, enable and mode terms, shared by the properties.
    logic req;
    logic in_ram;
    logic en;
    logic exp;
    assign req = cpu_req.read || cpu_req.write;
    assign in_ram = cpu_req.addr >= 16'hFF80 - RAM_BYTES && cpu_req.addr <= RAM_END_ADDR;
    assign en = system_control.onchip_ram_enable;
    assign exp = operating_mode inside {MODE_EXPANDED_ROMLESS, MODE_EXPANDED};
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    a_done_follows: assert property (req && !cpu_halt |=> cpu_done)
        else $error("done missing after a request");
    a_no_stray_done: assert property (!req || cpu_halt |=> !cpu_done)
        else $error("done without a taken request");
    a_halt_mode: assert property (cpu_halt == (operating_mode == MODE_PROGRAM))
        else $error("halt does not match mode");
    a_rom_decode: assert property (rom_select == (cpu_req.read && int'(cpu_req.addr) < ROM_KBYTES * 1024
        && (operating_mode == MODE_EXPANDED || operating_mode == MODE_SINGLE_CHIP)))
        else $error("rom select decode wrong");
    a_mode_frozen: assert property ($past(resetn) |-> $stable(operating_mode))
        else $error("mode changed outside reset");
    a_reset_ctrl: assert property ($rose(resetn) |-> system_control == 6'h01)
        else $error("control not at reset value");
    a_enable_cause: assert property ($changed(en) |-> $past(cpu_req.write && cpu_req.addr == SYSTEM_CONTROL_ADDR))
        else $error("enable changed without a write");
    a_inert_read: assert property (operating_mode == MODE_SINGLE_CHIP && !en && cpu_req.read && in_ram
        |=> cpu_rdata == ($past(cpu_req.word) ? INERT_READ_WORD : 16'h00FF))
        else $error("inert read not all ones");
    a_single_no_ext: assert property (operating_mode == MODE_SINGLE_CHIP |-> !ext_select)
        else $error("external cycle in single-chip mode");
    a_ext_route: assert property (exp && !en && req && in_ram |-> ext_select && ext_write == cpu_req.write)
        else $error("disabled window not external");
    a_ram_internal: assert property (en && req && in_ram |-> !ext_select && !rom_select)
        else $error("enabled window left the chip");
    c_inert: cover property (operating_mode == MODE_SINGLE_CHIP && !en && cpu_req.read && in_ram);
    c_ext: cover property (exp && !en && req && in_ram);
    c_rom: cover property (rom_select);
endmodule : onchip_memory_decode_monitor
bind onchip_memory_decode onchip_memory_decode_monitor #(.RAM_BYTES(RAM_BYTES), .ROM_KBYTES(ROM_KBYTES)) u_monitor (
    .clock, .resetn, .cpu_req, .cpu_rdata, .cpu_done, .cpu_halt, .rom_select, .ext_select, .ext_write,
    .operating_mode, .system_control);

// *** tb/mem_far_model.sv ***
/* ROM array and external bus seen from the decoder.
   Assumes both words are sampled in the request cycle. */
`timescale 1ns/10ps
module mem_far_model (
    input wire logic clock,
    input wire logic [15:0] addr,
    input wire logic rom_select,
    input wire logic ext_select,
    output logic [15:0] rom_rdata,
    output logic [15:0] ext_rdata
);
    // Unselected buses churn, so a late sample shows up.
    logic [15:0] churn = 16'h0000;
    always @(posedge clock) churn <= churn + 16'h3B1D;
    assign rom_rdata = rom_select ? ~{addr[15:1], 1'b0} : churn;
    assign ext_rdata = ext_select ? {addr[15:1], 1'b0} ^ 16'h5A5A : ~churn;
endmodule : mem_far_model

// *** tb/onchip_memory_decode_tb.sv ***
/* Self-checking bench for the memory decoder.
   Assumes the monitor is bound and the far model answers at once. */
`timescale 1ns/10ps
module onchip_memory_decode_tb
    import onchip_memory_decode_pkg::*;
;
    localparam int RAMB = 1024; // Smaller sizes move both decode edges.
    localparam int ROMK = 48;
    logic clock = 0;
    logic resetn = 0;
    logic md_hi = 0;
    logic md_lo = 0;
    cpu_request_s req = '0;
    logic [15:0] cpu_rdata, rom_rdata, ext_rdata, seed, a;
    logic cpu_done, cpu_halt, rom_select, ext_select, ext_read, ext_write;
    mode_e operating_mode;
    system_control_s system_control;
    int n_errors = 0;
    int n_compared = 0;
    int mode;
    logic [7:0] ram [int]; // Byte model of the RAM array.
    logic [7:0] ctrl; // Model of the control register.
    logic [15:0] probes [6] = '{16'h0000, 16'hBFFF, 16'hC000, 16'hFB7F, 16'hFF7F, 16'hF780};
    onchip_memory_decode #(.RAM_BYTES(RAMB), .ROM_KBYTES(ROMK)) DUT (.clock, .resetn, .mode_select_hi(md_hi),
        .mode_select_lo(md_lo), .cpu_req(req), .cpu_rdata, .cpu_done, .cpu_halt, .rom_select, .rom_rdata,
        .ext_select, .ext_read, .ext_write, .ext_rdata, .operating_mode, .system_control);
    mem_far_model far (.clock, .addr(req.addr), .rom_select, .ext_select, .rom_rdata, .ext_rdata);
    always #4 clock = ~clock;
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expv);
        n_compared++;
        if (seen !== expv) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, expv, seen);
        end
    endtask : check
    task automatic test_done;
        $display("compared %0d mismatched %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    // Where an address lands: 0 control, 1 ROM, 2 RAM, 3 external, 4 inert.
    function automatic int route(input logic [15:0] ad);
        if (mode == 0 || ad == SYSTEM_CONTROL_ADDR) return 0;
        if (mode != 1 && ad < ROMK * 1024) return 1;
        if (ad >= 16'hFF80 - RAMB && ad <= RAM_END_ADDR && ctrl[0]) return 2;
        return mode == 3 ? 4 : 3;
    endfunction : route
    // One strobe cycle, then the answer cycle.
    task automatic access(input logic wr, input logic wd, input logic [15:0] ad, input logic [15:0] dat);
        int r;
        logic [15:0] w;
        r = route(ad);
        w = r == 0 ? {ctrl, 8'h00} : r == 1 ? ~{ad[15:1], 1'b0} : r == 3 ? {ad[15:1], 1'b0} ^ 16'h5A5A
            : r == 2 ? {ram[{ad[15:1], 1'b0}], ram[{ad[15:1], 1'b1}]} : INERT_READ_WORD;
        @(posedge clock);
        req <= '{addr: ad, wdata: dat, word: wd, write: wr, read: !wr};
        #1;
        check("route", {rom_select, ext_select, ext_read, ext_write}, {r == 1 && !wr, r == 3, r == 3 && !wr, r == 3 && wr});
        @(posedge clock);
        req <= '0;
        #1;
        check("done", cpu_done, mode != 0);
        if (!wr && mode != 0) check("rdata", cpu_rdata, wd ? w : {8'h00, ad[0] ? w[7:0] : w[15:8]});
        if (wr && r == 0 && mode != 0) ctrl = ((wd ? dat[15:8] : dat[7:0]) & 8'hF5) | 8'h0A;
        if (wr && r == 2) begin
            ram[wd ? {ad[15:1], 1'b0} : ad] = wd ? dat[15:8] : dat[7:0];
            if (wd) ram[{ad[15:1], 1'b1}] = dat[7:0];
        end
        check("ctrl", system_control, {ctrl[7:4], ctrl[2], ctrl[0]});
    endtask : access
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        $display("watchdog ran out");
        test_done();
    end
    initial begin
        seed = $urandom(32'h3BD2);
        repeat (3) @(posedge clock);
        for (int m = 3; m >= 0; m--) begin
            @(posedge clock);
            resetn <= 0;
            md_hi <= m[1];
            md_lo <= m[0];
            repeat (5) @(posedge clock);
            resetn <= 1;
            mode = m;
            ctrl = SYSTEM_CONTROL_RESET;
            @(posedge clock);
            md_hi <= !m[1];
            md_lo <= !m[0];
            check("halt", cpu_halt, m == 0);
            access(0, 0, SYSTEM_CONTROL_ADDR, 0);
            // Word writes, read back whole and by byte, edges first.
            for (int i = 0; i < 6; i++) begin
                a = i == 0 ? 16'hFF80 - RAMB : i == 1 ? 16'hFF7E : 16'hFF80 - RAMB + $urandom % RAMB;
                access(1, 1, a, $urandom);
                access(0, 1, a, 0);
                access(0, 0, a & 16'hFFFE, 0);
                access(0, 0, a | 16'h0001, 0);
            end
            foreach (probes[i]) access(0, 0, probes[i], 0);
            access(1, 0, 16'h0010, 16'h00AA);
            access(1, 1, SYSTEM_CONTROL_ADDR, 16'h00FF);
            access(1, 1, 16'hFF80 - RAMB, 16'hA5C3);
            access(0, 1, 16'hFF80 - RAMB, 0);
            access(0, 0, 16'hFF7F, 0);
            repeat (3) @(posedge clock);
            access(1, 0, SYSTEM_CONTROL_ADDR, 16'h00F5);
            access(0, 1, 16'hFF80 - RAMB, 0);
            check("mode", operating_mode, m);
            $display("mode %0d test done", m);
        end
        test_done();
    end
endmodule : onchip_memory_decode_tb
